//--- ici_top.sv
// Imager clear, flush, power-down control and I2C configuration slave
`timescale 1ns/1ps
`default_nettype none
`include "ici_map.svh"
module ici_top #(
    parameter int FLUSH_NS = `ICI_FLUSH_NS,
    parameter int WAKE_NS  = `ICI_WAKE_NS
) (
    input  wire logic       ref_clk_in,
    input  wire logic       reset_n_in,
    input  wire logic       acq_in,
    input  wire logic       pixel_flush_pulse_in,
    input  wire logic       frame_clear_pulse_in,
    input  wire logic       sleep_request_in,
    input  wire logic       read_pulse_in,
    input  wire logic       readout_done_in,
    input  wire logic [1:0] addr_select_low_pin_in,
    input  wire logic [1:0] addr_select_high_pin_in,
    input  wire logic       scl_in,
    input  wire logic       sda_in,
    output logic            sda_out,
    output logic            sda_oe_out,
    output logic            frame_available_out,
    output logic            cds_valid_out,
    output logic            readout_busy_out,
    output logic            flushing_out,
    output logic            powered_down_out,
    output logic            ready_out,
    output logic [1:0]      temp_sensor_en_out,
    output logic [3:0]      slave_addr_out
);
    localparam int FLUSH_CYC = (FLUSH_NS * `ICI_CLK_MHZ + 999) / 1000;
    localparam int WAKE_CYC  = (WAKE_NS * `ICI_CLK_MHZ + 999) / 1000;
    localparam int ACQ = 0, PIX = 1, CLR = 2, SLP = 3;
    localparam int RDP = 4, RDD = 5, SCL = 6, SDA = 7;

    if (FLUSH_CYC < 1 || FLUSH_CYC > 65536 || WAKE_CYC < 1
        || WAKE_CYC > 65536) begin : g_chk
        $error("ici_top: timing parameters out of range");
    end

    ici_pkg::ici_state_t q;
    ici_pkg::ici_state_t d;
    logic [11:0] pins;
    logic acq_rise, acq_fall, pix_rise, clr_rise, rdp_rise, rdd_rise;
    logic scl_rise, scl_fall, i2c_start, i2c_stop;
    logic inc, dec, wipe;
    logic [2:0] hit;
    logic [7:0] rd_byte;

    // Maps a register address to {hit, index}
    function automatic logic [2:0] reg_hit(input logic [7:0] a);
        case (a)
            `ICI_REG_IMG:  reg_hit = 3'h4;
            `ICI_REG_BW:   reg_hit = 3'h5;
            `ICI_REG_MISC: reg_hit = 3'h6;
            `ICI_REG_TEMP: reg_hit = 3'h7;
            default:       reg_hit = 3'h0;
        endcase
    endfunction : reg_hit

    function automatic ici_pkg::ici_state_t rst_state();
        ici_pkg::ici_state_t s;
        s = '0;
        s.ct = ici_pkg::ICI_CT_WAKE;
        s.cnt = 16'(WAKE_CYC - 1);
        s.pd = 1'b1;
        // Bus lines idle high; a low reset value would fake an SCL edge
        s.sync1[SDA:SCL] = 2'h3;
        s.sync2[SDA:SCL] = 2'h3;
        s.prev[SDA:SCL] = 2'h3;
        s.regs[0] = `ICI_RST_IMG;
        s.regs[1] = `ICI_RST_BW;
        s.regs[2] = `ICI_RST_MISC;
        s.regs[3] = `ICI_RST_TEMP;
        return s;
    endfunction : rst_state

    assign pins = {addr_select_high_pin_in, addr_select_low_pin_in,
                   sda_in, scl_in, readout_done_in, read_pulse_in,
                   sleep_request_in, frame_clear_pulse_in,
                   pixel_flush_pulse_in, acq_in};
    assign acq_rise = q.sync2[ACQ] & ~q.prev[ACQ];
    assign acq_fall = ~q.sync2[ACQ] & q.prev[ACQ];
    assign pix_rise = q.sync2[PIX] & ~q.prev[PIX];
    assign clr_rise = q.sync2[CLR] & ~q.prev[CLR];
    assign rdp_rise = q.sync2[RDP] & ~q.prev[RDP];
    assign rdd_rise = q.sync2[RDD] & ~q.prev[RDD];
    assign scl_rise = q.sync2[SCL] & ~q.prev[SCL];
    assign scl_fall = ~q.sync2[SCL] & q.prev[SCL];
    assign i2c_start = q.prev[SCL] & q.sync2[SCL] & q.prev[SDA]
                     & ~q.sync2[SDA];
    assign i2c_stop = q.prev[SCL] & q.sync2[SCL] & ~q.prev[SDA]
                    & q.sync2[SDA];

    always_comb begin
        d = q;
        inc = 1'b0;
        dec = 1'b0;
        wipe = 1'b0;
        hit = reg_hit(q.regaddr);
        rd_byte = hit[2] ? q.regs[hit[1:0]] : 8'h00;
        d.sync1 = pins;
        d.sync2 = q.sync1;
        d.prev = q.sync2;
        // Straps settle through the synchroniser before capture
        if (q.boot != 2'h3) begin
            d.boot = q.boot + 2'h1;
        end
        if (q.boot == 2'h2) begin
            d.addr = q.sync2[11:8];
        end
        case (q.ct)
            ici_pkg::ICI_CT_WAKE: begin
                if (q.cnt == 16'h0) begin
                    d.ct = ici_pkg::ICI_CT_FLUSH;
                    d.cnt = 16'(FLUSH_CYC - 1);
                    wipe = 1'b1;
                end else begin
                    d.cnt = q.cnt - 16'h1;
                end
            end
            ici_pkg::ICI_CT_FLUSH: begin
                // Acquisition edges fall on the floor here
                if (q.cnt == 16'h0) begin
                    d.ct = ici_pkg::ICI_CT_IDLE;
                end else begin
                    d.cnt = q.cnt - 16'h1;
                end
            end
            ici_pkg::ICI_CT_IDLE: begin
                if (q.sync2[SLP] && !q.rd_busy) begin
                    d.ct = ici_pkg::ICI_CT_SLEEP;
                    wipe = 1'b1;
                    d.cds_valid = 1'b0;
                end else begin
                    if (clr_rise) begin
                        wipe = 1'b1;
                        d.rd_busy = 1'b0;
                        d.cleared = q.cds_valid;
                    end
                    if (acq_rise && q.frames != `ICI_MAX_FRAMES) begin
                        d.ct = ici_pkg::ICI_CT_EXPOSE;
                    end else if (pix_rise && !q.sync2[ACQ]) begin
                        d.ct = ici_pkg::ICI_CT_FLUSH;
                        d.cnt = 16'(FLUSH_CYC - 1);
                    end
                end
            end
            ici_pkg::ICI_CT_EXPOSE: begin
                // Flush requests ignored while acquisition is high
                if (clr_rise) begin
                    wipe = 1'b1;
                    d.rd_busy = 1'b0;
                    d.cleared = q.cds_valid;
                end
                if (acq_fall) begin
                    d.ct = ici_pkg::ICI_CT_XFER;
                    d.cnt = 16'(`ICI_XFER_CYC - 1);
                end
            end
            ici_pkg::ICI_CT_XFER: begin
                // Clear and flush edges are dropped during the shift
                if (q.cnt == 16'h0) begin
                    d.ct = ici_pkg::ICI_CT_IDLE;
                    inc = 1'b1;
                    if (q.cleared) begin
                        d.cds_valid = 1'b0;
                        d.cleared = 1'b0;
                    end
                end else begin
                    d.cnt = q.cnt - 16'h1;
                end
            end
            ici_pkg::ICI_CT_SLEEP: begin
                wipe = 1'b1;
                if (!q.sync2[SLP]) begin
                    d.ct = ici_pkg::ICI_CT_WAKE;
                    d.cnt = 16'(WAKE_CYC - 1);
                end
            end
            default: begin
                d.ct = ici_pkg::ICI_CT_IDLE;
            end
        endcase
        if (rdd_rise && q.rd_busy) begin
            d.rd_busy = 1'b0;
        end
        if (rdp_rise && !q.rd_busy && q.frames != 3'h0 && !wipe
            && q.ct != ici_pkg::ICI_CT_SLEEP) begin
            d.rd_busy = 1'b1;
            d.cds_valid = 1'b1;
            d.cleared = 1'b0;
            dec = 1'b1;
        end
        d.frames = wipe ? 3'(inc) : q.frames + 3'(inc) - 3'(dec);

        // I2C slave; SCL is never driven, so no stretching
        if (i2c_start) begin
            d.is = ici_pkg::ICI_IS_RX;
            d.kind = ici_pkg::ICI_K_ADDR;
            d.bitcnt = 4'h0;
            d.drive = 1'b0;
        end else if (i2c_stop) begin
            d.is = ici_pkg::ICI_IS_IDLE;
            d.drive = 1'b0;
            d.pend_reset = 1'b0;
            d.pend_resample = 1'b0;
            if (q.pend_resample) begin
                d.boot = 2'h0;
            end
        end else begin
            case (q.is)
                ici_pkg::ICI_IS_RX: begin
                    if (scl_rise && q.bitcnt != 4'h8) begin
                        d.shreg = {q.shreg[6:0], q.sync2[SDA]};
                        d.bitcnt = q.bitcnt + 4'h1;
                    end
                    if (scl_fall && q.bitcnt == 4'h8) begin
                        d.bitcnt = 4'h0;
                        d.is = ici_pkg::ICI_IS_ACK;
                        d.drive = 1'b1;
                        case (q.kind)
                            ici_pkg::ICI_K_ADDR: begin
                                d.rw = q.shreg[0];
                                d.kind = ici_pkg::ICI_K_REG;
                                if (q.shreg == `ICI_GC_ADDR) begin
                                    d.kind = ici_pkg::ICI_K_GC;
                                end else if (q.shreg[7:1] !=
                                    {`ICI_ADDR_MSB, q.addr}) begin
                                    d.is = ici_pkg::ICI_IS_IDLE;
                                    d.drive = 1'b0;
                                end
                            end
                            ici_pkg::ICI_K_REG: begin
                                d.regaddr = q.shreg;
                                d.kind = ici_pkg::ICI_K_DATA;
                            end
                            ici_pkg::ICI_K_DATA: begin
                                if (hit[2]) begin
                                    d.regs[hit[1:0]] = q.shreg;
                                end
                                d.regaddr = q.regaddr + 8'h1;
                            end
                            default: begin
                                if (q.shreg == `ICI_GC_RESET) begin
                                    d.pend_reset = 1'b1;
                                end else if (q.shreg == `ICI_GC_RESAMPLE)
                                begin
                                    d.pend_resample = 1'b1;
                                end else begin
                                    d.is = ici_pkg::ICI_IS_IDLE;
                                    d.drive = 1'b0;
                                end
                            end
                        endcase
                    end
                end
                ici_pkg::ICI_IS_ACK: begin
                    if (scl_fall) begin
                        if (q.rw) begin
                            d.shreg = rd_byte;
                            d.drive = ~rd_byte[7];
                            d.is = ici_pkg::ICI_IS_TX;
                            d.bitcnt = 4'h0;
                        end else begin
                            d.drive = 1'b0;
                            d.is = ici_pkg::ICI_IS_RX;
                        end
                    end
                end
                ici_pkg::ICI_IS_TX: begin
                    if (scl_fall) begin
                        if (q.bitcnt == 4'h7) begin
                            d.drive = 1'b0;
                            d.is = ici_pkg::ICI_IS_MACK;
                        end else begin
                            d.shreg = {q.shreg[6:0], 1'b0};
                            d.drive = ~q.shreg[6];
                            d.bitcnt = q.bitcnt + 4'h1;
                        end
                    end
                end
                ici_pkg::ICI_IS_MACK: begin
                    if (scl_rise) begin
                        if (q.sync2[SDA]) begin
                            d.is = ici_pkg::ICI_IS_IDLE;
                        end else begin
                            d.regaddr = q.regaddr + 8'h1;
                            d.is = ici_pkg::ICI_IS_ACK;
                        end
                    end
                end
                default: begin
                    d.is = ici_pkg::ICI_IS_IDLE;
                end
            endcase
        end
        if (i2c_stop && q.pend_reset) begin
            d = rst_state();
            d.sync1 = pins;
            d.sync2 = q.sync1;
            d.prev = q.sync2;
        end
        d.favail = d.frames != 3'h0;
        d.pd = d.ct == ici_pkg::ICI_CT_SLEEP || d.ct == ici_pkg::ICI_CT_WAKE;
        d.ready = d.ct == ici_pkg::ICI_CT_IDLE;
        d.flushing = d.ct == ici_pkg::ICI_CT_FLUSH;
    end

    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            q <= rst_state();
        end else begin
            q <= d;
        end
    end

    assign sda_out = 1'b0;
    assign sda_oe_out = q.drive;
    assign frame_available_out = q.favail;
    assign cds_valid_out = q.cds_valid;
    assign readout_busy_out = q.rd_busy;
    assign flushing_out = q.flushing;
    assign powered_down_out = q.pd;
    assign ready_out = q.ready;
    assign temp_sensor_en_out = q.regs[3][`ICI_TEMP_EN_MSB:`ICI_TEMP_EN_LSB];
    assign slave_addr_out = q.addr;

    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (!reset_n_in);

    sequence xfer_run;
        ##25 (q.ct == ici_pkg::ICI_CT_XFER) ##1 q.ct == ici_pkg::ICI_CT_IDLE;
    endsequence
    sequence wake_to_flush;
        (q.ct == ici_pkg::ICI_CT_WAKE) ##1 q.ct == ici_pkg::ICI_CT_FLUSH;
    endsequence

    xfer_len_a: assert property (
        q.ct == ici_pkg::ICI_CT_EXPOSE && acq_fall |-> xfer_run)
        else $error("transfer length wrong");
    flush_block_a: assert property (
        q.ct == ici_pkg::ICI_CT_FLUSH && q.cnt != 16'h0
        |=> q.ct == ici_pkg::ICI_CT_FLUSH)
        else $error("acquisition accepted during flush");
    flush_drop_a: assert property (
        pix_rise && (q.sync2[ACQ] || q.ct == ici_pkg::ICI_CT_XFER)
        |=> q.ct != ici_pkg::ICI_CT_FLUSH)
        else $error("flush accepted during acquisition");
    sleep_wipe_a: assert property (
        q.ct == ici_pkg::ICI_CT_SLEEP |-> !q.favail && !q.rd_busy)
        else $error("frames kept in power-down");
    wake_flush_a: assert property (
        q.ct == ici_pkg::ICI_CT_WAKE && q.cnt == 16'h0 |-> wake_to_flush)
        else $error("no flush after wake");
    sleep_exit_a: assert property (
        q.ct == ici_pkg::ICI_CT_SLEEP && !q.sync2[SLP]
        |=> q.ct == ici_pkg::ICI_CT_WAKE && !q.ready)
        else $error("wake time skipped");
    clear_wipe_a: assert property (
        clr_rise && q.ct == ici_pkg::ICI_CT_IDLE && !q.sync2[SLP]
        |=> !q.favail && !q.rd_busy)
        else $error("clear did not erase");
    addr_ack_a: assert property (
        q.is == ici_pkg::ICI_IS_RX && scl_fall && q.bitcnt == 4'h8
        && q.kind == ici_pkg::ICI_K_ADDR && !i2c_start && !i2c_stop
        && q.shreg[7:1] == {`ICI_ADDR_MSB, q.addr} |=> sda_oe_out)
        else $error("own address not acknowledged");
    avail_hold_a: assert property (
        !q.favail && $past(q.favail)
        |-> $past(dec || wipe || (i2c_stop && q.pend_reset)))
        else $error("frame available dropped with frame stored");
endmodule : ici_top
`default_nettype wire

//--- ici_map.svh
// Offsets, reset values and timing figures of the imager control port
`ifndef ICI_MAP_SVH
`define ICI_MAP_SVH
`define ICI_CLK_MHZ        10
`define ICI_FLUSH_NS       2000
`define ICI_WAKE_NS        100000
`define ICI_MIN_CLR_NS     100
`define ICI_XFER_CYC       25
`define ICI_MAX_FRAMES     3'h4
`define ICI_ADDR_MSB       3'h1
`define ICI_GC_ADDR        8'h00
`define ICI_GC_RESET       8'h06
`define ICI_GC_RESAMPLE    8'h04
`define ICI_REG_IMG        8'h00
`define ICI_REG_BW         8'h01
`define ICI_REG_MISC       8'h02
`define ICI_REG_TEMP       8'hA4
`define ICI_RST_IMG        8'h14
`define ICI_RST_BW         8'h05
`define ICI_RST_MISC       8'h00
`define ICI_RST_TEMP       8'h00
`define ICI_TEMP_EN_LSB    0
`define ICI_TEMP_EN_MSB    1
`endif

//--- ici_pkg.sv
// Types shared by the imager control port
package ici_pkg;
    typedef enum logic [2:0] {
        ICI_CT_WAKE, ICI_CT_FLUSH, ICI_CT_IDLE,
        ICI_CT_EXPOSE, ICI_CT_XFER, ICI_CT_SLEEP
    } ici_ctl_t;
    typedef enum logic [2:0] {
        ICI_IS_IDLE, ICI_IS_RX, ICI_IS_ACK, ICI_IS_TX, ICI_IS_MACK
    } ici_i2c_t;
    typedef enum logic [1:0] {
        ICI_K_ADDR, ICI_K_REG, ICI_K_DATA, ICI_K_GC
    } ici_kind_t;
    typedef struct packed {
        logic [11:0]      sync1;
        logic [11:0]      sync2;
        logic [11:0]      prev;
        logic [1:0]       boot;
        ici_ctl_t         ct;
        logic [15:0]      cnt;
        logic [2:0]       frames;
        logic             rd_busy;
        logic             cds_valid;
        logic             cleared;
        logic             favail;
        logic             pd;
        logic             ready;
        logic             flushing;
        ici_i2c_t         is;
        ici_kind_t        kind;
        logic [3:0]       bitcnt;
        logic [7:0]       shreg;
        logic             rw;
        logic             drive;
        logic [7:0]       regaddr;
        logic             pend_reset;
        logic             pend_resample;
        logic [3:0]       addr;
        logic [3:0][7:0]  regs;
    } ici_state_t;
endpackage : ici_pkg

//--- ici_host_model.sv
// Controller-side I2C master model driving the configuration port
`timescale 1ns/1ps
`default_nettype none
module ici_host_model (
    input  wire logic clk_in,
    input  wire logic sda_bus_in,
    output var logic  scl_out,
    output var logic  sda_low_out
);
    // Idle bus: clock parked high, data left to the pull-up
    initial begin
        scl_out = 1'b1;
        sda_low_out = 1'b0;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clk_in);
    endtask : tick
    // Fixed 800 ns bit; never waits on SCL, so any stretch would be missed
    task automatic bit_io(input logic b, output logic r);
        sda_low_out <= ~b;
        tick(2);
        scl_out <= 1'b1;
        tick(2);
        r = sda_bus_in;
        tick(2);
        scl_out <= 1'b0;
        tick(2);
    endtask : bit_io
    task automatic xfer(input logic [7:0] d, output logic [7:0] q);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], r);
            q[i] = r;
        end
    endtask : xfer
    // Also serves as repeated start after an acked byte
    task automatic start_cond();
        sda_low_out <= 1'b0;
        tick(2);
        scl_out <= 1'b1;
        tick(2);
        sda_low_out <= 1'b1;
        tick(2);
        scl_out <= 1'b0;
        tick(2);
    endtask : start_cond
    task automatic stop_cond();
        sda_low_out <= 1'b1;
        tick(2);
        scl_out <= 1'b1;
        tick(2);
        sda_low_out <= 1'b0;
        tick(4);
    endtask : stop_cond
endmodule : ici_host_model
`default_nettype wire

//--- ici_top_test.sv
// Self-checking bench for the imager clear, power and I2C control port
`timescale 1ns/1ps
`default_nettype none
`include "ici_map.svh"
module ici_top_test;
    localparam int WK_NS = 2000;
    logic clk = 1'b0, rst_n = 1'b0, acq = 1'b0, flush = 1'b0, clr = 1'b0;
    logic slp = 1'b0, rdp = 1'b0, rdd = 1'b0, scl, host_low, sda_w;
    logic sda_o, sda_oe, favail, cds, busy, fl, pd, rdy;
    logic [1:0] cs_lo, cs_hi, temp;
    logic [3:0] saddr;
    logic [7:0] rv [3] = '{`ICI_RST_IMG, `ICI_RST_BW, `ICI_RST_MISC};
    int fails = 0, compares = 0;
    string nm_q[$];
    logic [7:0] exp_q[$], got_q[$];

    always #50 clk = ~clk;
    // Open-drain line with pull-up
    assign sda_w = ~(host_low | (sda_oe & ~sda_o));

    ici_top #(.FLUSH_NS(1000), .WAKE_NS(WK_NS)) dut_u (
        .ref_clk_in(clk), .reset_n_in(rst_n), .acq_in(acq),
        .pixel_flush_pulse_in(flush), .frame_clear_pulse_in(clr),
        .sleep_request_in(slp), .read_pulse_in(rdp),
        .readout_done_in(rdd), .addr_select_low_pin_in(cs_lo),
        .addr_select_high_pin_in(cs_hi), .scl_in(scl), .sda_in(sda_w),
        .sda_out(sda_o), .sda_oe_out(sda_oe), .frame_available_out(favail),
        .cds_valid_out(cds), .readout_busy_out(busy), .flushing_out(fl),
        .powered_down_out(pd), .ready_out(rdy),
        .temp_sensor_en_out(temp), .slave_addr_out(saddr));
    ici_host_model host_u (.clk_in(clk), .sda_bus_in(sda_w),
        .scl_out(scl), .sda_low_out(host_low));

    task automatic check(string nm, logic [7:0] got, logic [7:0] ex);
        compares++;
        if (got !== ex) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", nm, ex, got);
        end
    endtask : check
    task automatic note(string nm, logic [7:0] got, logic [7:0] ex);
        nm_q.push_back(nm);
        got_q.push_back(got);
        exp_q.push_back(ex);
    endtask : note
    always @(negedge clk) begin
        while (got_q.size() > 0) begin
            check(nm_q.pop_front(), got_q.pop_front(), exp_q.pop_front());
        end
    end
    task automatic print_verdict();
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : print_verdict
    function automatic logic [1:0] code(input logic [1:0] k);
        return {k[1], |k};
    endfunction : code
    task automatic wait_on(input logic sel, output int n, output logic saw);
        saw = 1'b0;
        for (n = 0; n < 3000; n++) begin
            @(posedge clk);
            saw |= fl;
            if ((sel ? favail : rdy) === 1'b1) return;
        end
        fails++;
        print_verdict();
    endtask : wait_on
    task automatic acquire(input logic pix);
        int n;
        logic saw;
        acq <= 1'b1;
        repeat (16) @(posedge clk);
        flush <= pix;
        repeat (6) @(posedge clk);
        note("flush_in_acq", 8'(fl), 8'h00);
        acq <= 1'b0;
        flush <= 1'b0;
        wait_on(1'b1, n, saw);
        note("xfer_len", 8'(n >= 24 && n <= 30), 8'h01);
    endtask : acquire
    task automatic send(input logic [7:0] b, output logic ack);
        logic [7:0] q;
        host_u.xfer(b, q);
        host_u.bit_io(1'b1, ack);
    endtask : send
    task automatic hdr(input logic [7:0] rg);
        logic a;
        host_u.start_cond();
        send({`ICI_ADDR_MSB, cs_hi, cs_lo, 1'b0}, a);
        note("ack_addr", 8'(a), 8'h00);
        send(rg, a);
        note("ack_reg", 8'(a), 8'h00);
    endtask : hdr
    task automatic gcall(input logic [7:0] cmd);
        logic a;
        host_u.start_cond();
        send(`ICI_GC_ADDR, a);
        note("ack_gc", 8'(a), 8'h00);
        send(cmd, a);
        note("ack_cmd", 8'(a), 8'h00);
        host_u.stop_cond();
        repeat (8) @(posedge clk);
    endtask : gcall

    initial begin
        logic [7:0] q;
        logic a, saw;
        logic [1:0] t;
        int n;
        void'($urandom(95));
        cs_lo <= code(2'($urandom % 3));
        cs_hi <= code(2'($urandom % 3));
        t = 2'($urandom % 3) + 2'h1;
        repeat (5) @(posedge clk);
        note("pd_rst", 8'(pd), 8'h01);
        note("temp_rst", 8'(temp), 8'h00);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        note("addr", 8'(saddr), {4'h0, cs_hi, cs_lo});
        note("early_rdy", 8'(rdy), 8'h00);
        wait_on(1'b0, n, saw);
        acquire(1'b1);
        repeat (10) @(posedge clk);
        note("held", 8'(favail), 8'h01);
        rdp <= 1'b1;
        repeat (2) @(posedge clk);
        rdp <= 1'b0;
        repeat (6) @(posedge clk);
        note("busy", 8'(busy), 8'h01);
        // Clear and acquisition rise on the same edge
        clr <= 1'b1;
        acq <= 1'b1;
        repeat (6) @(posedge clk);
        note("abort", 8'(busy), 8'h00);
        note("cds_kept", 8'(cds), 8'h01);
        note("erased", 8'(favail), 8'h00);
        clr <= 1'b0;
        acquire(1'b0);
        clr <= 1'b1;
        repeat (3) @(posedge clk);
        clr <= 1'b0;
        repeat (6) @(posedge clk);
        note("clear_only", 8'(favail), 8'h00);
        flush <= 1'b1;
        @(posedge clk);
        acq <= 1'b1;
        repeat (3) @(posedge clk);
        acq <= 1'b0;
        flush <= 1'b0;
        repeat (40) @(posedge clk);
        note("acq_in_flush", 8'(favail), 8'h00);
        acquire(1'b0);
        rdp <= 1'b1;
        repeat (2) @(posedge clk);
        rdp <= 1'b0;
        // Read-out left running so power-down has to wait for it
        acquire(1'b0);
        slp <= 1'b1;
        repeat (8) @(posedge clk);
        note("sleep_wait", 8'(pd), 8'h00);
        rdd <= 1'b1;
        repeat (8) @(posedge clk);
        note("sleep", 8'(pd), 8'h01);
        note("frames_lost", 8'(favail), 8'h00);
        rdd <= 1'b0;
        slp <= 1'b0;
        wait_on(1'b0, n, saw);
        note("wake_flush", 8'(saw), 8'h01);
        note("wake_len", 8'(n >= WK_NS / 100), 8'h01);
        hdr(8'hA3);
        send(8'h5A, a);
        note("ack_unimpl", 8'(a), 8'h00);
        send({6'h00, t}, a);
        note("ack_data", 8'(a), 8'h00);
        note("temp_on", 8'(temp), {6'h00, t});
        host_u.stop_cond();
        hdr(`ICI_REG_IMG);
        host_u.start_cond();
        send({`ICI_ADDR_MSB, cs_hi, cs_lo, 1'b1}, a);
        note("ack_rd", 8'(a), 8'h00);
        for (int i = 0; i < 3; i++) begin
            host_u.xfer(8'hFF, q);
            host_u.bit_io(i == 2, a);
            note("rd_data", q, rv[i]);
        end
        host_u.stop_cond();
        host_u.start_cond();
        send({`ICI_ADDR_MSB, ~cs_hi, ~cs_lo, 1'b0}, a);
        note("foreign", 8'(a), 8'h01);
        host_u.stop_cond();
        cs_lo <= (cs_lo == 2'b00) ? 2'b11 : 2'b00;
        cs_hi <= code(2'($urandom % 3));
        gcall(`ICI_GC_RESAMPLE);
        note("resample", 8'(saddr), {4'h0, cs_hi, cs_lo});
        gcall(`ICI_GC_RESET);
        note("sw_reset", 8'(temp), 8'h00);
        wait_on(1'b0, n, saw);
        repeat (2) @(negedge clk);
        print_verdict();
    end
endmodule : ici_top_test
`default_nettype wire
